// File: dv/cpu_instruction_subset_exec_tb.sv
// Self-checking testbench for the instruction subset execution unit.
`timescale 1ns/1ps
module cpu_instruction_subset_exec_tb
   import exec_pkg::*;
;
   ////////////////////////////////////////////////////////////////////////
   // Stimulus and observed signals; the stimulus ones are given a value at time zero.
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic insn_valid = 1'b0;
   logic [INSN_W-1:0] insn = 14'h0000;
   logic [DATA_W-1:0] file_rd_data = 8'h00;
   logic [DATA_W-1:0] program_page_latch = 8'h00;
   logic [FADDR_W-1:0] file_rd_addr;
   file_wr_t file_wr;
   logic [DATA_W-1:0] accum;
   logic zero_flag;
   logic [IP_W-1:0] instruction_pointer;
   logic flush_busy;
   int fail_count = 0;
   int checks = 0;

   // Free-running 250 MHz clock.
   always #2 clk_sys = ~clk_sys;

   exec_core exec_core_inst (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .insn_valid(insn_valid),
      .insn(insn),
      .file_rd_data(file_rd_data),
      .program_page_latch(program_page_latch),
      .file_rd_addr(file_rd_addr),
      .file_wr(file_wr),
      .accum(accum),
      .zero_flag(zero_flag),
      .instruction_pointer(instruction_pointer),
      .flush_busy(flush_busy)
   );

   ////////////////////////////////////////////////////////////////////////
   // Compare tasks, one for each width of result.
   task automatic cmp8(input string what, input logic [7:0] e,
                       input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp1(input string what, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic cmp15(input string what, input logic [14:0] e,
                        input logic [14:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask

   // Instruction word builders for file and literal forms.
   function automatic logic [13:0] fop(input logic [5:0] op,
      input logic d, input logic [6:0] f);
      return {op, d, f};
   endfunction
   function automatic logic [13:0] lop(input logic [5:0] op,
      input logic [7:0] k);
      return {op, k};
   endfunction

   // Offers one instruction at the falling edge; returns once the
   // taking edge has settled, so results are read in the answer cycle.
   task automatic issue(input logic [13:0] w, input logic [7:0] fd);
      @(negedge clk_sys);
      insn_valid = 1'b1;
      insn = w;
      file_rd_data = fd;
      @(posedge clk_sys);
      #1;
   endtask

   // Offers a branch together with a new paging latch value, both at
   // the falling edge, so the taking edge sees them settled.
   task automatic issue_branch(input logic [7:0] page,
                               input logic [10:0] k);
      @(negedge clk_sys);
      program_page_latch = page;
      insn_valid = 1'b1;
      insn = {OP_BRANCH, k};
      file_rd_data = 8'h00;
      @(posedge clk_sys);
      #1;
   endtask

   // Checks the forced no-op slot: an offered OR that would change the
   // accumulator must be thrown away, and the slot lasts one cycle.
   task automatic flush_slot(input logic [7:0] acc);
      cmp1("flush_busy", 1'b1, flush_busy);
      issue(lop(OP_OR_LIT, 8'hff), 8'h00);
      cmp8("accum", acc, accum);
      cmp1("flush_busy", 1'b0, flush_busy);
      // A write-back pulse must not outlive its own cycle.
      cmp1("file_wr.wr", 1'b0, file_wr.wr);
   endtask

   // Checks one write-back toward the file bank.
   task automatic cmp_wr(input logic [6:0] a, input logic [7:0] d);
      cmp1("file_wr.wr", 1'b1, file_wr.wr);
      cmp8("file_wr.addr", {1'b0, a}, {1'b0, file_wr.addr});
      cmp8("file_wr.data", d, file_wr.data);
      cmp8("file_rd_addr", {1'b0, a}, {1'b0, file_rd_addr});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_or_lit;
      issue(lop(OP_OR_LIT, 8'h00), 8'h00);
      cmp1("zero_flag", 1'b1, zero_flag);
      issue(lop(OP_OR_LIT, 8'h5a), 8'h00);
      cmp8("accum", 8'h5a, accum);
      cmp1("zero_flag", 1'b0, zero_flag);
      $display("test or_lit done");
   endtask

   // Wrap to zero into the accumulator, then a write to the top address.
   task automatic t_inc;
      issue(fop(OP_PLAIN_INC, 1'b0, 7'h12), 8'hff);
      cmp8("accum", 8'h00, accum);
      cmp1("zero_flag", 1'b1, zero_flag);
      cmp1("file_wr.wr", 1'b0, file_wr.wr);
      issue(fop(OP_PLAIN_INC, 1'b1, 7'h7f), 8'h41);
      cmp_wr(7'h7f, 8'h42);
      cmp8("accum", 8'h00, accum);
      cmp1("zero_flag", 1'b0, zero_flag);
      cmp1("flush_busy", 1'b0, flush_busy);
      $display("test plain_inc done");
   endtask

   // Zero results skip and leave the flag alone; nonzero ones do not skip.
   task automatic t_skips;
      issue(fop(OP_DEC_SKIP, 1'b1, 7'h33), 8'h01);
      cmp_wr(7'h33, 8'h00);
      cmp1("zero_flag", 1'b0, zero_flag);
      flush_slot(8'h00);
      cmp15("pointer", 15'h0006, instruction_pointer);
      issue(fop(OP_DEC_SKIP, 1'b0, 7'h00), 8'h00);
      cmp8("accum", 8'hff, accum);
      cmp1("flush_busy", 1'b0, flush_busy);
      issue(fop(OP_INC_SKIP, 1'b0, 7'h01), 8'hff);
      cmp8("accum", 8'h00, accum);
      cmp1("zero_flag", 1'b0, zero_flag);
      flush_slot(8'h00);
      issue(fop(OP_INC_SKIP, 1'b1, 7'h02), 8'h10);
      cmp_wr(7'h02, 8'h11);
      cmp1("flush_busy", 1'b0, flush_busy);
      $display("test skips done");
   endtask

   task automatic t_or_file;
      issue(lop(OP_OR_LIT, 8'h0c), 8'h00);
      issue(fop(OP_OR_FILE, 1'b1, 7'h05), 8'h30);
      cmp_wr(7'h05, 8'h3c);
      cmp8("accum", 8'h0c, accum);
      issue(fop(OP_OR_FILE, 1'b0, 7'h06), 8'h81);
      cmp8("accum", 8'h8d, accum);
      cmp1("file_wr.wr", 1'b0, file_wr.wr);
      $display("test or_file done");
   endtask

   // Some latch bits outside the page field are set so that a wrong slice
   // of the latch shows up in the pointer.
   task automatic t_branch;
      issue_branch(8'hd5, 11'h455);
      cmp15("pointer", 15'h5455, instruction_pointer);
      flush_slot(8'h8d);
      cmp15("pointer", 15'h5456, instruction_pointer);
      issue_branch(8'h2a, 11'h7ff);
      cmp15("pointer", 15'h2fff, instruction_pointer);
      flush_slot(8'h8d);
      $display("test branch done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Verdict and run control.
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Watchdog: a hung sequence counts as a mismatch.
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      end_of_test;
   end

   // Reset for ten cycles, check the cleared state, then run the tests.
   initial begin
      repeat (10) @(posedge clk_sys);
      #1;
      cmp8("accum", 8'h00, accum);
      cmp1("zero_flag", 1'b0, zero_flag);
      cmp15("pointer", 15'h0000, instruction_pointer);
      cmp1("flush_busy", 1'b0, flush_busy);
      cmp1("file_wr.wr", 1'b0, file_wr.wr);
      $display("test reset done");
      @(negedge clk_sys);
      rst_b = 1'b1;
      t_or_lit;
      t_inc;
      t_skips;
      t_or_file;
      t_branch;
      end_of_test;
   end
endmodule // cpu_instruction_subset_exec_tb

// File: hdl/exec_core.sv
// Execution unit for a subset of the 8-bit core's instructions.
// What this block does
// - Destination bit picks accumulator or file.
// - Decrement-skip skips next when result zero.
// - Increment-skip skips next when result zero.
// - Branch loads eleven-bit literal into pointer.
// - Branch fills pointer top bits from latch.
// - Branch always takes two cycles.
// - OR literal into accumulator, update zero.
// - Plain increment updates zero, never skips.
// - OR file with accumulator, update zero.
`timescale 1ns/1ps
module exec_core
   import exec_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // Instruction in, valid each cycle the fetch offers one.
   input wire logic insn_valid,
   input wire logic [INSN_W-1:0] insn,
   // File register read data for the addressed location.
   input wire logic [DATA_W-1:0] file_rd_data,
   // Paging latch value from the register file.
   input wire logic [DATA_W-1:0] program_page_latch,
   // File address of the instruction taken at the last clock edge, registered.
   output logic [FADDR_W-1:0] file_rd_addr,
   // Write back toward the file register bank.
   output file_wr_t file_wr,
   // Architectural state.
   output logic [DATA_W-1:0] accum,
   output logic zero_flag,
   output logic [IP_W-1:0] instruction_pointer,
   // High while the current cycle is a forced no-operation.
   output logic flush_busy
);

   ////////////////////////////////////////////////////////////////////////
   // Decode.

   // Decoded kind of the incoming instruction.
   opkind_t kind;

   exec_decode u_decode (
      .insn(insn),
      .kind(kind)
   );

   // Operand fields.
   // seven-bit file field
   wire logic [FADDR_W-1:0] faddr = insn[FADDR_W-1:0];
   wire logic dest_file = insn[DEST_BIT];
   wire logic [DATA_W-1:0] lit8 = insn[DATA_W-1:0];
   wire logic [LIT_W-1:0] lit11 = insn[LIT_W-1:0];

   // State and registers.
   exec_state_t state_reg, state_next;
   logic [DATA_W-1:0] accum_reg, accum_next;
   logic zero_reg, zero_next;
   logic [IP_W-1:0] ip_reg, ip_next;
   file_wr_t wr_reg, wr_next;
   logic [FADDR_W-1:0] raddr_reg;

   // An instruction executes only in the run state.
   wire logic exec_ok = insn_valid && (state_reg == ST_RUN);

   ////////////////////////////////////////////////////////////////////////
   // Arithmetic.

   wire logic [DATA_W-1:0] inc_val = DATA_W'(file_rd_data + DATA_ONE);
   wire logic [DATA_W-1:0] dec_val = DATA_W'(file_rd_data - DATA_ONE);
   wire logic [DATA_W-1:0] orf_val = accum_reg | file_rd_data;
   wire logic [DATA_W-1:0] orl_val = accum_reg | lit8;

   // Result chosen per kind.
   wire logic [DATA_W-1:0] result =
      (kind == OPK_DEC_SKIP) ? dec_val :
      (kind == OPK_OR_FILE) ? orf_val :
      (kind == OPK_OR_LIT) ? orl_val : inc_val;

   // Instructions that write a destination chosen by the d bit.
   wire logic uses_dest = (kind == OPK_DEC_SKIP) ||
      (kind == OPK_INC_SKIP) || (kind == OPK_PLAIN_INC) ||
      (kind == OPK_OR_FILE);

   wire logic skip_hit = exec_ok && (result == DATA_ZERO) &&
      ((kind == OPK_DEC_SKIP) || (kind == OPK_INC_SKIP));

   wire logic z_upd = (kind == OPK_PLAIN_INC) ||
      (kind == OPK_OR_FILE) || (kind == OPK_OR_LIT);

   wire logic [IP_W-1:0] branch_tgt =
      {program_page_latch[PAGE_HI:PAGE_LO], lit11};

   ////////////////////////////////////////////////////////////////////////
   // Next state.

   // Computes every register's next value for the cycle except raddr_reg, which takes faddr directly.
   always_comb begin
      state_next = ST_RUN;
      accum_next = accum_reg;
      zero_next = zero_reg;
      ip_next = ip_reg;
      wr_next = '{wr: 1'b0, addr: faddr, data: result};
      if (exec_ok) begin
         ip_next = IP_M(ip_reg);
         if (uses_dest && !dest_file) begin
            accum_next = result;
         end
         if (uses_dest && dest_file) begin
            wr_next.wr = 1'b1;
         end
         if (kind == OPK_OR_LIT) begin
            accum_next = orl_val;
         end
         if (z_upd) begin
            zero_next = (result == DATA_ZERO);
         end
         if (kind == OPK_BRANCH) begin
            ip_next = branch_tgt;
            state_next = ST_FLUSH;
         end
         if (skip_hit) begin
            state_next = ST_FLUSH;
         end
      end else if (insn_valid) begin
         // Discarded slot still advances past the skipped word.
         ip_next = IP_M(ip_reg);
      end
   end

   // Pointer advance helper.
   function automatic logic [IP_W-1:0] IP_M(input logic [IP_W-1:0] p);
      IP_M = IP_W'(p + IP_STEP);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers.

   // Synchronous active-low reset of all control state.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_reg <= ST_RUN;
         accum_reg <= DATA_ZERO;
         zero_reg <= 1'b0;
         ip_reg <= IP_RESET;
         wr_reg <= '0;
         raddr_reg <= '0;
      end else begin
         state_reg <= state_next;
         accum_reg <= accum_next;
         zero_reg <= zero_next;
         ip_reg <= ip_next;
         wr_reg <= wr_next;
         raddr_reg <= faddr;
      end
   end

   // Outputs straight from flip-flops.
   assign accum = accum_reg;
   assign zero_flag = zero_reg;
   assign instruction_pointer = ip_reg;
   assign file_wr = wr_reg;
   assign flush_busy = (state_reg == ST_FLUSH);
   assign file_rd_addr = raddr_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   AST_SKIP_FLUSH:
      assert property (@(posedge clk_sys) disable iff (!rst_b)
         skip_hit |=> flush_busy ##1 !flush_busy && $stable(accum))
      else $error("skip did not flush exactly one cycle");

   AST_BRANCH_TARGET:
      assert property (@(posedge clk_sys) disable iff (!rst_b)
         exec_ok && kind == OPK_BRANCH |=>
            instruction_pointer[LIT_W-1:0] == $past(lit11))
      else $error("branch low bits wrong");

   AST_BRANCH_PAGE:
      assert property (@(posedge clk_sys) disable iff (!rst_b)
         exec_ok && kind == OPK_BRANCH |=>
            instruction_pointer[IP_W-1:LIT_W] ==
            $past(program_page_latch[PAGE_HI:PAGE_LO]))
      else $error("branch page bits wrong");

   AST_BRANCH_TWO:
      assert property (@(posedge clk_sys) disable iff (!rst_b)
         exec_ok && kind == OPK_BRANCH |=> flush_busy ##1 !flush_busy)
      else $error("branch not two cycles");

   AST_DEST_ACC:
      assert property (@(posedge clk_sys) disable iff (!rst_b)
         exec_ok && uses_dest && !dest_file |=>
            !file_wr.wr && accum == $past(result))
      else $error("accumulator destination wrong");

   AST_ORLIT:
      assert property (@(posedge clk_sys) disable iff (!rst_b)
         exec_ok && kind == OPK_OR_LIT |=>
            accum == ($past(accum) | $past(lit8)) &&
            zero_flag == (accum == DATA_ZERO))
      else $error("literal OR wrong");

   AST_INC_NOSKIP:
      assert property (@(posedge clk_sys) disable iff (!rst_b)
         exec_ok && kind == OPK_PLAIN_INC |=>
            !flush_busy && zero_flag == ($past(inc_val) == DATA_ZERO))
      else $error("plain increment wrong");

   AST_ORFILE:
      assert property (@(posedge clk_sys) disable iff (!rst_b)
         exec_ok && kind == OPK_OR_FILE && dest_file |=>
            file_wr.wr && file_wr.data == $past(orf_val) &&
            zero_flag == (file_wr.data == DATA_ZERO))
      else $error("file OR wrong");

   AST_SKIP_FLAGS:
      assert property (@(posedge clk_sys) disable iff (!rst_b)
         exec_ok && (kind == OPK_DEC_SKIP || kind == OPK_INC_SKIP) |=>
            $stable(zero_flag))
      else $error("skip form changed zero flag");

   AST_INC_SKIP:
      assert property (@(posedge clk_sys) disable iff (!rst_b)
         exec_ok && kind == OPK_INC_SKIP && inc_val != DATA_ZERO |=>
            !flush_busy)
      else $error("nonzero increment skipped");

endmodule // exec_core

// File: hdl/exec_decode.sv
// Combinational opcode decoder for the instruction subset.
`timescale 1ns/1ps
module exec_decode
   import exec_pkg::*;
(
   // Instruction word in.
   input wire logic [INSN_W-1:0] insn,
   // Decoded kind out.
   output opkind_t kind
);

   // Upper opcode groups of the instruction word.
   wire logic [5:0] top6 = insn[INSN_W-1:INSN_W-6];
   wire logic [2:0] top3 = insn[INSN_W-1:INSN_W-3];

   // Branch is checked first since its group is widest.
   assign kind = (top3 == OP_BRANCH) ? OPK_BRANCH :
                 (top6 == OP_DEC_SKIP) ? OPK_DEC_SKIP :
                 (top6 == OP_INC_SKIP) ? OPK_INC_SKIP :
                 (top6 == OP_PLAIN_INC) ? OPK_PLAIN_INC :
                 (top6 == OP_OR_FILE) ? OPK_OR_FILE :
                 (top6 == OP_OR_LIT) ? OPK_OR_LIT : OPK_NONE;

endmodule // exec_decode

// File: hdl/exec_pkg.sv
// Shared constants and types for the instruction subset execution unit.
package exec_pkg;

   // Data path and address widths.
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int LIT_W = 11;
   localparam int IP_W = 15;

   // Width of the 14-bit instruction word, its d bit, and the page field of the paging latch.
   localparam int INSN_W = 14;
   localparam int DEST_BIT = 7;
   localparam int PAGE_LO = 3;
   localparam int PAGE_HI = 6;

   // Fixed data values.
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
   localparam logic [IP_W-1:0] IP_RESET = 15'h0000;
   localparam logic [IP_W-1:0] IP_STEP = 15'h0001;

   // Opcode patterns: six-bit groups and the branch three-bit group.
   localparam logic [5:0] OP_DEC_SKIP = 6'h0b;
   localparam logic [5:0] OP_INC_SKIP = 6'h0f;
   localparam logic [5:0] OP_PLAIN_INC = 6'h0a;
   localparam logic [5:0] OP_OR_FILE = 6'h04;
   localparam logic [5:0] OP_OR_LIT = 6'h38;
   localparam logic [2:0] OP_BRANCH = 3'h5;

   // Decoded operation kinds.
   typedef enum logic [2:0] {
      OPK_NONE = 3'b000,
      OPK_DEC_SKIP = 3'b001,
      OPK_INC_SKIP = 3'b010,
      OPK_PLAIN_INC = 3'b011,
      OPK_OR_FILE = 3'b100,
      OPK_OR_LIT = 3'b101,
      OPK_BRANCH = 3'b110
   } opkind_t;

   // Execution states: normal run or forced no-operation cycle.
   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_FLUSH = 1'b1
   } exec_state_t;

   // Result of one executed instruction toward the file register bank.
   typedef struct packed {
      logic wr;
      logic [FADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } file_wr_t;

endpackage
